// File: core/mag_agc.sv
`timescale 1ns/100ps
// Contract
// - Gain follows level against target
// - Envelope segments sized from frame and rate
// - Rise after hold quiet segments, decay steps
// - Over target (1.5 times target unless tight) cuts gain at once, in ST_FALL at the next step
// - Noise segments never move gain
// - Gate zeroes noise-only output audio
// - Gain changes wait for zero crossing
// - Manual gain 6 to 36 dB
// - Silence bit mutes preamplifier
// - Internal microphone single-ended option
// - External microphone select bit
// - Bias level, only matching pin active
// - Capless virtual ground select
// - Headset key series or parallel
// - Parallel key settle 0 to 32 ms
// - Monitor feed attenuation field
// - Phone input gain field
// - Phone input silence bit
// - Loop enable selects automatic gain
// - Frame time table 96 to 1000 ms
// - Fall step time 32 to 4096 ms
// - Hold count 0 to 31 segments
module mag_agc #(
  parameter int KEY_CNT_W    = 20,
  parameter int KEY_UNIT_CYC = mag_pkg::KEY_UNIT_CYC
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    nrst_i,
  input  wire logic [7:0]              reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  input  wire mag_pkg::mag_sample_type adc_sample_i,
  input  wire logic                    key_raw_i,
  output logic [7:0]                   reg_rdata_o,
  output mag_pkg::mag_sample_type      capture_o,
  output mag_pkg::mag_ctrl_type        ctrl_o,
  output logic                         key_pressed_o,
  output logic                         noise_gated_o
);

  typedef enum logic [1:0] {ST_WAIT, ST_RISE, ST_FALL} mag_state_type;

  logic [1:0]                             rst_sync_ff;
  logic                                   rst_n;
  logic [mag_pkg::REG_COUNT-1:0][7:0]     reg_ff;
  mag_state_type                          state_ff, nxt_state;
  logic [3:0]                             gain_ff, nxt_gain;
  logic [3:0]                             applied_ff;
  logic [4:0]                             hold_ff, nxt_hold;
  logic [17:0]                            step_ff, nxt_step;
  logic                                   over_seen_ff, nxt_over_seen;
  logic                                   prev_sign_ff;
  logic                                   gate_want_ff;
  logic                                   seg_done;
  logic [15:0]                            seg_peak;
  logic                                   key_stable;

  // ==========================================================
  // Reset release through two flops
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // ==========================================================
  // Register file decode
  wire [7:0] idx     = reg_addr_i - mag_pkg::ADDR_FIRST;
  wire       hit     = (reg_addr_i >= mag_pkg::ADDR_FIRST) && (reg_addr_i <= mag_pkg::ADDR_PHONE);
  wire [3:0] idx_s   = idx[3:0];
  wire [7:0] r_rate  = reg_ff[mag_pkg::ADDR_RATE - mag_pkg::ADDR_FIRST];
  wire [7:0] r_seg   = reg_ff[mag_pkg::ADDR_SEGMENT - mag_pkg::ADDR_FIRST];
  wire [7:0] r_l1    = reg_ff[mag_pkg::ADDR_LOOP_ONE - mag_pkg::ADDR_FIRST];
  wire [7:0] r_l2    = reg_ff[mag_pkg::ADDR_LOOP_TWO - mag_pkg::ADDR_FIRST];
  wire [7:0] r_l3    = reg_ff[mag_pkg::ADDR_LOOP_THREE - mag_pkg::ADDR_FIRST];
  wire [7:0] r_m1    = reg_ff[mag_pkg::ADDR_MIC_ONE - mag_pkg::ADDR_FIRST];
  wire [7:0] r_m2    = reg_ff[mag_pkg::ADDR_MIC_TWO - mag_pkg::ADDR_FIRST];
  wire [7:0] r_mon   = reg_ff[mag_pkg::ADDR_MONITOR - mag_pkg::ADDR_FIRST];
  wire [7:0] r_ph    = reg_ff[mag_pkg::ADDR_PHONE - mag_pkg::ADDR_FIRST];

  // Writes store the byte, reads of unmapped offsets give zero
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_ff      <= mag_pkg::REG_RESET;
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      if (reg_wr_i && hit)
        reg_ff[idx_s] <= reg_wdata_i;
      reg_rdata_o <= (reg_rd_i && hit) ? reg_ff[idx_s] : 8'h00;
    end
  end

  // ==========================================================
  // Field extraction
  wire       loop_en   = r_l1[mag_pkg::POS_LOOP_EN];
  wire [2:0] tgt_code  = r_l1[mag_pkg::POS_TARGET +: 3];
  wire       gate_on   = r_l1[mag_pkg::POS_GATE_ON];
  wire [2:0] noise_cd  = r_l1[mag_pkg::POS_NOISE +: 3];
  wire [3:0] max_gain  = r_l2[mag_pkg::POS_MAX_GAIN +: 4];
  wire [2:0] rise_cd   = r_l2[mag_pkg::POS_RISE_STEP +: 3];
  wire       tight     = r_l2[mag_pkg::POS_TIGHT];
  wire [4:0] hold_need = r_l3[mag_pkg::POS_HOLD +: 5];
  wire [2:0] fall_cd   = r_l3[mag_pkg::POS_FALL_STEP +: 3];
  wire [1:0] rate_cd   = r_rate[mag_pkg::POS_RATE +: 2];
  wire [3:0] man_gain  = r_m1[mag_pkg::POS_GAIN +: 4];
  wire       seg_zc_off = r_seg[mag_pkg::POS_GATE_SEG];

  // ==========================================================
  // Segment and step lengths in samples
  // segment sizing
  wire [17:0] seg_len  = mag_pkg::mag_samples(
                           13'(mag_pkg::FRAME_MS[r_seg[mag_pkg::POS_FRAME +: 3]]), rate_cd);
  wire [17:0] fall_len = mag_pkg::mag_samples(13'(mag_pkg::STEP_BASE_MS << fall_cd), rate_cd);
  wire [17:0] rise_len = mag_pkg::mag_samples(13'(mag_pkg::STEP_BASE_MS << rise_cd), rate_cd);

  mag_envelope u_env (
    .clk_i      (clk_sys_i),
    .rst_n_i    (rst_n),
    .smp_i      (adc_sample_i),
    .seg_len_i  (seg_len),
    .seg_done_o (seg_done),
    .seg_peak_o (seg_peak)
  );

  // ==========================================================
  // Level comparisons
  wire [15:0] tgt_lvl   = mag_pkg::TARGET_LVL[tgt_code];
  wire [16:0] over_lvl  = tight ? {1'b0, tgt_lvl} : 17'({1'b0, tgt_lvl} + {2'b00, tgt_lvl[15:1]});
  wire [15:0] mag_now   = mag_pkg::mag_abs(adc_sample_i.data);
  wire        smp_over  = adc_sample_i.valid && ({1'b0, mag_now} > over_lvl);
  wire [15:0] noise_lvl = 16'h7fff >> (4'(mag_pkg::NOISE_TOP_SHIFT) - {1'b0, noise_cd});
  wire        seg_sig   = seg_peak > noise_lvl;
  wire        seg_quiet = seg_done && seg_sig && (seg_peak < tgt_lvl);
  wire        seg_loud  = seg_done && seg_sig && (seg_peak >= tgt_lvl);
  wire        step_due  = adc_sample_i.valid && (step_ff == 18'h00000);
  wire [3:0]  gain_dn   = (gain_ff != 4'h0) ? gain_ff - 4'h1 : gain_ff;
  wire [3:0]  gain_up   = (gain_ff < max_gain) ? gain_ff + 4'h1 : gain_ff;
  wire [4:0]  hold_inc  = (hold_ff != 5'h1f) ? hold_ff + 5'h01 : hold_ff;

  // ==========================================================
  // Gain loop next state
  always_comb
  begin
    nxt_state     = state_ff;
    nxt_gain      = gain_ff;
    nxt_hold      = hold_ff;
    nxt_over_seen = over_seen_ff;
    nxt_step      = (adc_sample_i.valid && step_ff != 18'h00000) ? step_ff - 18'h00001 : step_ff;
    if (!loop_en)
    begin
      nxt_state     = ST_WAIT;
      nxt_gain      = man_gain;
      nxt_hold      = 5'h00;
      nxt_over_seen = 1'b0;
    end
    else if (smp_over && state_ff != ST_FALL)
    begin
      nxt_state     = ST_FALL;
      nxt_gain      = gain_dn;
      nxt_hold      = 5'h00;
      nxt_step      = fall_len - 18'h00001;
      nxt_over_seen = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_FALL:
        begin
          if (smp_over)
            nxt_over_seen = 1'b1;
          if (step_due && over_seen_ff)
          begin
            nxt_gain      = gain_dn;
            nxt_step      = fall_len - 18'h00001;
            nxt_over_seen = 1'b0;
          end
          else if (step_due)
            nxt_state = ST_WAIT;
        end
        ST_WAIT:
        begin
          if (seg_loud)
            nxt_hold = 5'h00;
          else if (seg_quiet)
          begin
            nxt_hold = hold_inc;
            if (hold_inc >= hold_need)
            begin
              nxt_state = ST_RISE;
              nxt_step  = rise_len - 18'h00001;
            end
          end
        end
        ST_RISE:
        begin
          if (seg_loud)
          begin
            nxt_state = ST_WAIT;
            nxt_hold  = 5'h00;
          end
          else if (step_due)
          begin
            nxt_gain = gain_up;
            nxt_step = rise_len - 18'h00001;
          end
        end
      endcase
    end
    if (nxt_gain > max_gain && loop_en)
      nxt_gain = max_gain;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff     <= ST_WAIT;
      gain_ff      <= 4'h0;
      hold_ff      <= 5'h00;
      step_ff      <= 18'h00000;
      over_seen_ff <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      gain_ff      <= nxt_gain;
      hold_ff      <= nxt_hold;
      step_ff      <= nxt_step;
      over_seen_ff <= nxt_over_seen;
    end
  end

  // ==========================================================
  // Zero crossing, applied gain, noise gate
  wire zc = adc_sample_i.valid &&
            ((adc_sample_i.data[15] != prev_sign_ff) || (adc_sample_i.data == 16'h0000));
  wire gate_edge = seg_zc_off ? seg_done : zc;

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_sign_ff  <= 1'b0;
      applied_ff    <= 4'h0;
      gate_want_ff  <= 1'b0;
      noise_gated_o <= 1'b0;
      capture_o     <= '0;
    end
    else
    begin
      if (adc_sample_i.valid)
        prev_sign_ff <= adc_sample_i.data[15];
      if (zc)
        applied_ff <= loop_en ? gain_ff : man_gain;
      if (seg_done)
        gate_want_ff <= gate_on && !seg_sig;
      if (gate_edge || !gate_on)
        noise_gated_o <= gate_on && (seg_done ? !seg_sig : gate_want_ff);
      capture_o.valid <= adc_sample_i.valid;
      capture_o.data  <= noise_gated_o ? 16'h0000 : adc_sample_i.data;
    end
  end

  mag_debounce #(
    .CNT_W    (KEY_CNT_W),
    .UNIT_CYC (KEY_UNIT_CYC)
  ) u_key (
    .clk_i    (clk_sys_i),
    .rst_n_i  (rst_n),
    .raw_i    (key_raw_i),
    .series_i (r_m2[mag_pkg::POS_KEY_TYPE]),
    .settle_i (r_m2[mag_pkg::POS_KEY_SETTLE +: 2]),
    .stable_o (key_stable)
  );

  // ==========================================================
  // Registered analog controls
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_o        <= '0;
      key_pressed_o <= 1'b0;
    end
    else
    begin
      ctrl_o.amp_gain                      <= applied_ff;
      ctrl_o.mic_amp_silence               <= r_m1[mag_pkg::POS_SILENCE];
      ctrl_o.internal_mic_single_ended     <= r_m1[mag_pkg::POS_INT_SE];
      ctrl_o.external_mic_select           <= r_m1[mag_pkg::POS_EXT_SEL];
      ctrl_o.int_bias_en                   <= !r_m1[mag_pkg::POS_EXT_SEL];
      ctrl_o.outer_mic_bias_pin_en         <= r_m1[mag_pkg::POS_EXT_SEL];
      ctrl_o.mic_bias_level                <= r_m2[mag_pkg::POS_BIAS +: 2];
      ctrl_o.capless_virtual_ground_select <= r_m2[mag_pkg::POS_VCM];
      ctrl_o.key_series                    <= r_m2[mag_pkg::POS_KEY_TYPE];
      ctrl_o.monitor_feed_attenuation      <= r_mon[mag_pkg::POS_MON_ATT +: 4];
      ctrl_o.phone_input_gain              <= r_ph[mag_pkg::POS_PH_GAIN +: 5];
      ctrl_o.phone_input_silence           <= r_ph[mag_pkg::POS_PH_MUTE];
      key_pressed_o                        <= key_stable;
    end
  end

  // ==========================================================
  // Checks
  chk_fall_now: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    loop_en && smp_over && state_ff != ST_FALL && gain_ff != 4'h0 && gain_ff <= max_gain
    |=> gain_ff == $past(gain_ff) - 4'h1 && state_ff == ST_FALL)
    else $error("gain not cut at once");
  chk_gain_ceiling: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    loop_en |=> gain_ff <= $past(max_gain))
    else $error("gain above maximum");
  chk_zc_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    !zc |=> $stable(applied_ff))
    else $error("gain changed off crossing");
  chk_manual_gain: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    !loop_en && zc |=> ##1 ctrl_o.amp_gain == $past(man_gain, 2))
    else $error("manual gain not applied");
  chk_noise_still: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    loop_en && state_ff == ST_WAIT && seg_done && !seg_sig && !smp_over |=> $stable(gain_ff))
    else $error("noise moved gain");
  chk_rise_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    state_ff == ST_WAIT ##1 state_ff == ST_RISE |-> $past(seg_quiet) && hold_ff >= hold_need)
    else $error("rise before hold");
  chk_gate_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    noise_gated_o && adc_sample_i.valid |=> capture_o.valid && capture_o.data == 16'h0000)
    else $error("gated audio passed");
  chk_silence_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    reg_wr_i && reg_addr_i == mag_pkg::ADDR_MIC_ONE
    |=> ##1 ctrl_o.mic_amp_silence == $past(reg_wdata_i[mag_pkg::POS_SILENCE], 2))
    else $error("silence bit not applied");
  chk_one_bias: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    !(ctrl_o.int_bias_en && ctrl_o.outer_mic_bias_pin_en))
    else $error("both bias pins on");
  cov_fall: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    state_ff == ST_FALL ##1 state_ff == ST_WAIT);
  cov_rise: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    state_ff == ST_RISE && step_due);
  cov_gate: cover property (@(posedge clk_sys_i) disable iff (!rst_n) $rose(noise_gated_o));

endmodule : mag_agc

// File: core/mag_debounce.sv
`timescale 1ns/100ps
module mag_debounce #(
  parameter int CNT_W    = 20,
  parameter int UNIT_CYC = mag_pkg::KEY_UNIT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       raw_i,
  input  wire logic       series_i,
  input  wire logic [1:0] settle_i,
  output logic            stable_o
);

  logic [CNT_W-1:0] cnt_ff;

  if (UNIT_CYC * 4 >= (1 << CNT_W))
  begin : g_check
    $error("mag_debounce: CNT_W too narrow for UNIT_CYC");
  end

  // Settle length: 0, 1, 2 or 4 units
  wire [CNT_W-1:0] unit  = CNT_W'(UNIT_CYC);
  wire [CNT_W-1:0] limit = (settle_i == 2'b01) ? unit :
                           (settle_i == 2'b10) ? CNT_W'(unit << 1) : CNT_W'(unit << 2);
  wire             bypass = series_i || (settle_i == 2'b00);

  // ==========================================================
  // Accept a change only after it stood long enough
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff   <= '0;
      stable_o <= 1'b0;
    end
    else if (bypass || raw_i == stable_o)
    begin
      cnt_ff   <= '0;
      stable_o <= raw_i;
    end
    else if (cnt_ff >= limit - CNT_W'(1))
    begin
      cnt_ff   <= '0;
      stable_o <= raw_i;
    end
    else
    begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

endmodule : mag_debounce

// File: core/mag_envelope.sv
`timescale 1ns/100ps
module mag_envelope (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire mag_pkg::mag_sample_type smp_i,
  input  wire logic [17:0]             seg_len_i,
  output logic                         seg_done_o,
  output logic [15:0]                  seg_peak_o
);

  logic [17:0] cnt_ff;
  logic [15:0] run_ff;
  wire  [15:0] mag_now  = mag_pkg::mag_abs(smp_i.data);
  wire  [15:0] peak_now = (mag_now > run_ff) ? mag_now : run_ff;
  wire         last     = smp_i.valid && (cnt_ff >= seg_len_i - 18'h00001);

  // ==========================================================
  // Peak per segment of samples
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff     <= 18'h00000;
      run_ff     <= 16'h0000;
      seg_done_o <= 1'b0;
      seg_peak_o <= 16'h0000;
    end
    else
    begin
      seg_done_o <= last;
      if (last)
      begin
        cnt_ff     <= 18'h00000;
        run_ff     <= 16'h0000;
        seg_peak_o <= peak_now;
      end
      else if (smp_i.valid)
      begin
        cnt_ff <= cnt_ff + 18'h00001;
        run_ff <= peak_now;
      end
    end
  end

endmodule : mag_envelope

// File: core/mag_pkg.sv
package mag_pkg;

  // ==========================================================
  // Register offsets (byte addresses on the control port)
  localparam logic [7:0] ADDR_FIRST      = 8'h06;
  localparam logic [7:0] ADDR_RATE       = 8'h06;
  localparam logic [7:0] ADDR_SEGMENT    = 8'h07;
  localparam logic [7:0] ADDR_LOOP_ONE   = 8'h08;
  localparam logic [7:0] ADDR_LOOP_TWO   = 8'h09;
  localparam logic [7:0] ADDR_LOOP_THREE = 8'h0a;
  localparam logic [7:0] ADDR_MIC_ONE    = 8'h0b;
  localparam logic [7:0] ADDR_MIC_TWO    = 8'h0c;
  localparam logic [7:0] ADDR_MONITOR    = 8'h0d;
  localparam logic [7:0] ADDR_PHONE      = 8'h0e;
  localparam int         REG_COUNT       = 9;

  // Reset values, index 0 is offset 0x06
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {9{8'h00}};

  // ==========================================================
  // Field positions
  localparam int POS_RATE      = 4;
  localparam int POS_FRAME     = 2;
  localparam int POS_GATE_SEG  = 7;
  localparam int POS_LOOP_EN   = 0;
  localparam int POS_TARGET    = 1;
  localparam int POS_GATE_ON   = 4;
  localparam int POS_NOISE     = 5;
  localparam int POS_MAX_GAIN  = 0;
  localparam int POS_RISE_STEP = 4;
  localparam int POS_TIGHT     = 7;
  localparam int POS_HOLD      = 0;
  localparam int POS_FALL_STEP = 5;
  localparam int POS_GAIN      = 0;
  localparam int POS_SILENCE   = 4;
  localparam int POS_INT_SE    = 5;
  localparam int POS_EXT_SEL   = 6;
  localparam int POS_VCM       = 0;
  localparam int POS_BIAS      = 1;
  localparam int POS_KEY_TYPE  = 3;
  localparam int POS_KEY_SETTLE = 4;
  localparam int POS_MON_ATT   = 0;
  localparam int POS_PH_GAIN   = 0;
  localparam int POS_PH_MUTE   = 5;

  // ==========================================================
  // Timing and level tables
  localparam int STEP_BASE_MS   = 32;
  localparam int KEY_UNIT_MS    = 8;
  localparam int CLK_KHZ        = 20000;
  localparam int KEY_UNIT_CYC   = KEY_UNIT_MS * CLK_KHZ;
  localparam int NOISE_TOP_SHIFT = 12;
  localparam logic [7:0][9:0]  FRAME_MS   = {10'd1000, 10'd768, 10'd512, 10'd384,
                                             10'd256, 10'd192, 10'd128, 10'd96};
  localparam logic [3:0][4:0]  RATE_KHZ   = {5'd24, 5'd16, 5'd12, 5'd8};
  localparam logic [7:0][15:0] TARGET_LVL = {16'h0ccd, 16'h101d, 16'h1449, 16'h198a,
                                             16'h2027, 16'h287a, 16'h32f5, 16'h4027};

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } mag_sample_type;

  typedef struct packed {
    logic [3:0] amp_gain;
    logic       mic_amp_silence;
    logic       internal_mic_single_ended;
    logic       external_mic_select;
    logic       int_bias_en;
    logic       outer_mic_bias_pin_en;
    logic [1:0] mic_bias_level;
    logic       capless_virtual_ground_select;
    logic       key_series;
    logic [3:0] monitor_feed_attenuation;
    logic [4:0] phone_input_gain;
    logic       phone_input_silence;
  } mag_ctrl_type;

  // Magnitude of a two's complement sample
  function automatic logic [15:0] mag_abs(input logic [15:0] d);
    mag_abs = d[15] ? 16'(-d) : d;
  endfunction : mag_abs

  // Milliseconds to samples at the expected capture rate
  function automatic logic [17:0] mag_samples(input logic [12:0] ms, input logic [1:0] rate);
    mag_samples = 18'(ms) * 18'(RATE_KHZ[rate]);
  endfunction : mag_samples

endpackage : mag_pkg

// File: verification/mag_adc_model.sv
`timescale 1ns/100ps
// ==========================================================
// Preamplifier and mono capture source
module mag_adc_model (
  input  wire logic               clk_i,
  input  wire logic               go_i,
  input  wire logic [15:0]        lvl_i,
  output mag_pkg::mag_sample_type smp_o
);
  initial smp_o = '0;
  // no high-pass, so samples carry the bench level unchanged
  // no samples while the bench holds go_i low
  // Idle data toggles so stale values never look valid
  always @(posedge clk_i)
  begin
    smp_o <= #1 '{valid: go_i, data: go_i ? lvl_i : ~smp_o.data};
  end
endmodule : mag_adc_model

// File: verification/tb_mag_agc.sv
`timescale 1ns/100ps
// ==========================================================
// Bench for the microphone gain and input control block
module tb_mag_agc;
  logic                    clk_sys_i = 0;
  logic                    nrst_i = 0;
  logic                    wr = 0, rd = 0, rd_d = 0, go = 0, key = 0;
  logic [7:0]              addr = '0, wd = '0, rdata;
  logic [7:0]              r [4];
  logic [3:0]              gn [2] = '{4'h5, 4'h0};
  logic [15:0]             lvl = '0;
  logic                    kp, ng;
  mag_pkg::mag_sample_type smp, cap;
  mag_pkg::mag_ctrl_type   ctrl;
  int                      bad_count = 0;
  int                      n_tests = 0;
  logic [15:0]             cap_q [$];
  logic [7:0]              rd_q [$];

  always #25 clk_sys_i = ~clk_sys_i;

  mag_adc_model u_adc (.clk_i(clk_sys_i), .go_i(go), .lvl_i(lvl), .smp_o(smp));
  mag_agc #(.KEY_UNIT_CYC(10)) DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .adc_sample_i(smp), .key_raw_i(key),
    .reg_rdata_o(rdata), .capture_o(cap), .ctrl_o(ctrl), .key_pressed_o(kp),
    .noise_gated_o(ng));

  // ==========================================================
  // Compare, bus and sample tasks
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1 {addr, wd, wr} = {a, d, 1'b1};
    @(posedge clk_sys_i);
    #1 wr = 0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge clk_sys_i);
    #1 {addr, rd} = {a, 1'b1};
    @(posedge clk_sys_i);
    #1 rd = 0;
  endtask : rreg

  // Burst of n equal samples; gated ones are expected as silence
  task automatic snd(input logic [15:0] v, input int n = 1, input logic gated = 1'b0);
    repeat (n) cap_q.push_back(gated ? 16'h0000 : v);
    @(posedge clk_sys_i);
    #1 {go, lvl} = {1'b1, v};
    repeat (n) @(posedge clk_sys_i);
    #1 go = 0;
  endtask : snd

  // Expected control outputs from the register copies
  function automatic mag_pkg::mag_ctrl_type ectl();
    ectl = '{r[0][3:0], r[0][4], r[0][5], r[0][6], !r[0][6], r[0][6], r[1][2:1],
             r[1][0], r[1][3], r[2][3:0], r[3][4:0], r[3][5]};
  endfunction : ectl

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Output watcher takes the oldest note per result, mid-cycle
  always @(negedge clk_sys_i)
  begin
    if (rd_d)
      check("rdata", rdata, rd_q.pop_front());
    if (cap.valid === 1'b1)
      check("capture", cap.data, cap_q.pop_front());
    rd_d <= rd;
  end

  // Watchdog, about four times the expected run
  initial
  begin
    repeat (12000) @(posedge clk_sys_i);
    bad_count++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    void'($urandom(48735));
    repeat (8) @(posedge clk_sys_i);
    #1 nrst_i = 1;
    repeat (3) @(posedge clk_sys_i);
    for (int i = 0; i < 4; i++) rreg(8'h0b + 8'(i), 8'h00);
    check("bias", ctrl.int_bias_en, 1);
    // Random settings reach fields; unmapped place ignored
    repeat (4)
    begin
      foreach (r[i])
      begin
        r[i] = 8'($urandom);
        wreg(8'h0b + 8'(i), r[i]);
      end
      wreg(8'h0f, 8'hff);
      snd(16'h0000);
      foreach (r[i]) rreg(8'h0b + 8'(i), r[i]);
      rreg(8'h0f, 8'h00);
      check("ctrl", ctrl, ectl());
      check("gate", ng, 0);
    end
    // Over-target sample cuts gain once, floor holds
    wreg(8'h0d, 8'h00); // monitor feed cut while mic settles
    wreg(8'h0c, 8'h00);
    wreg(8'h09, 8'h8f); // tight target, max gain 15
    wreg(8'h0a, 8'h00);
    foreach (gn[i])
    begin
      wreg(8'h08, 8'h00);
      wreg(8'h0b, {4'h0, gn[i]});
      snd(16'h0000);
      wreg(8'h08, 8'h01);
      snd(16'h7000);
      snd(16'h0000);
      repeat (4) @(posedge clk_sys_i);
      #1 check("gain", ctrl.amp_gain, (gn[i] == 0) ? 0 : gn[i] - 1);
    end
    // Noise-only segment gates the output, loop stays on
    wreg(8'h08, 8'h11);
    snd(16'h0000, 1536);
    snd(16'h0001, 1, 1'b1);
    check("gate", ng, 1);
    // Quiet signal segment starts the rise, one step
    wreg(8'h08, 8'h01);
    snd(16'h1000, 1153);
    snd(16'h0000);
    repeat (4) @(posedge clk_sys_i);
    #1 check("gain", ctrl.amp_gain, 1);
    // Parallel key with zero settle passes through
    key = 1;
    repeat (4) @(posedge clk_sys_i);
    #1 check("key", kp, 1);
    // Parallel key with one settle unit waits it out
    wreg(8'h0c, 8'h10);
    key = 0;
    repeat (5) @(posedge clk_sys_i);
    #1 check("key", kp, 1);
    repeat (8) @(posedge clk_sys_i);
    #1 check("key", kp, 0);
    // Series key skips the settle time
    wreg(8'h0c, 8'h18);
    key = 1;
    repeat (3) @(posedge clk_sys_i);
    #1 check("key", kp, 1);
    print_verdict();
  end
endmodule : tb_mag_agc
